// ==== core/mbs_crc16.sv ====
/*
  One-byte update of the 16-bit frame check, reflected polynomial.
  Purely combinational; the caller holds the running value.
*/
module mbs_crc16
  import mbs_pkg::*;
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc_out
);

  // ---------------------------------------------------------------
  // eight shift steps per byte
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ MBS_CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end

endmodule

// ==== core/mbs_pkg.sv ====
/*
  Package of the serial slave port: register map, reset values, timing
  counts, state and storage types, and the bit-period function.
  Assumes a single 20 MHz system clock.
*/
package mbs_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int          MBS_CLK_HZ       = 20_000_000;
  localparam int          MBS_MS_US        = 1000;            // 1 ms
  localparam int          MBS_MS_CYCLES    = MBS_CLK_HZ / 1_000_000 * MBS_MS_US;
  localparam int          MBS_LOSS_STEP_MS = 100;             // 0.1 s step
  localparam logic [6:0]  MBS_TXWAIT_MIN   = 7'h05;           // 5 ms
  localparam logic [6:0]  MBS_TXWAIT_MAX   = 7'h41;           // 65 ms
  localparam logic [6:0]  MBS_LOSS_MAX     = 7'h64;           // 10.0 s
  localparam logic [5:0]  MBS_GAP_BITS     = 6'h23;           // 3.5 chars
  localparam int          MBS_BAUD [0:8]   = '{1200, 2400, 4800, 9600,
    19200, 38400, 57600, 76800, 115200};
  localparam logic [3:0]  MBS_BAUD_DEF     = 4'h3;

  // ---------------------------------------------------------------
  // protocol constants
  // ---------------------------------------------------------------
  localparam logic [15:0] MBS_CRC_POLY  = 16'ha001;
  localparam logic [15:0] MBS_CRC_INIT  = 16'hffff;
  localparam logic [7:0]  MBS_FN_READ   = 8'h03;
  localparam logic [7:0]  MBS_FN_WRITE  = 8'h06;
  localparam logic [15:0] MBS_CMD_REG   = 16'h0001;  // run command bits
  localparam logic [15:0] MBS_VOLT_REG  = 16'h0025;  // output voltage
  localparam logic [15:0] MBS_ENTER_REG = 16'h0900;  // enter command
  localparam logic [1:0]  MBS_PAR_NONE  = 2'h0;
  localparam logic [1:0]  MBS_PAR_EVEN  = 2'h1;
  localparam logic [1:0]  MBS_PAR_ODD   = 2'h2;

  // ---------------------------------------------------------------
  // parameter registers
  // ---------------------------------------------------------------
  localparam int MBS_NREG      = 11;
  localparam int MBS_I_ADDR    = 0;
  localparam int MBS_I_RATE    = 1;
  localparam int MBS_I_PAR     = 2;
  localparam int MBS_I_STOP    = 3;
  localparam int MBS_I_LOSS_EN = 4;
  localparam int MBS_I_TXWAIT  = 5;
  localparam int MBS_I_RTS     = 6;
  localparam int MBS_I_LOSS_T  = 7;
  localparam int MBS_I_VUNIT   = 8;
  localparam int MBS_I_ENTER   = 9;
  localparam int MBS_I_RUNM    = 10;
  localparam logic [MBS_NREG-1:0][15:0] MBS_REG_OFS = {
    16'h043d, 16'h043c, 16'h0436, 16'h0435, 16'h042b, 16'h042a,
    16'h0429, 16'h0428, 16'h0427, 16'h0426, 16'h0425};
  localparam logic [MBS_NREG-1:0][15:0] MBS_REG_RST = {
    16'h0000, 16'h0000, 16'h0000, 16'h0014, 16'h0001, 16'h0005,
    16'h0000, 16'h0003, 16'h0000, 16'h0003, 16'h001f};

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MBS_ST_IDLE = 2'h0,
    MBS_ST_WAIT = 2'h1,
    MBS_ST_SEND = 2'h3
  } mbs_st_t;

  typedef struct packed {
    logic [MBS_NREG-1:0][15:0] shadow;
    logic [MBS_NREG-1:0][15:0] live;
    logic [7:0]                act_addr;
    logic [3:0]                act_rate;
    logic [1:0]                act_par;
    logic                      rx_busy;
    logic [14:0]               rx_cnt;
    logic [3:0]                rx_bit;
    logic [9:0]                rx_sh;
    logic [5:0]                idle_bits;
    logic [3:0]                nbytes;
    logic                      rx_bad;
    logic [15:0]               rx_crc;
    logic [7:0][7:0]           rx_buf;
    mbs_st_t                   st;
    logic [14:0]               ms_cnt;
    logic [6:0]                wait_ms;
    logic [6:0]                tenth_cnt;
    logic [6:0]                loss_cnt;
    logic                      fault;
    logic [14:0]               tx_cnt;
    logic [3:0]                tx_bits;
    logic [9:0]                tx_sh;
    logic                      tx_line;
    logic [3:0]                tx_idx;
    logic [3:0]                tx_len;
    logic [15:0]               tx_crc;
    logic [5:0][7:0]           tx_buf;
    logic [1:0]                cmd;
    logic                      run_fwd;
    logic                      run_rev;
    logic [1:0]                stop_act;
  } mbs_state_t;

  // clock cycles of one bit for a line rate code and clock rate, rounded
  function automatic logic [14:0] mbs_bit_cycles(input logic [3:0] code,
                                                 input int         clk_hz);
    int b;
    b = (code > 4'h8) ? MBS_BAUD[MBS_BAUD_DEF] : MBS_BAUD[code];
    return 15'((clk_hz + b / 2) / b);
  endfunction

endpackage

// ==== core/mbs_port.sv ====
/*
  Serial slave port of a motor drive: receives request frames, keeps the
  communication parameter registers, answers read and write requests,
  drives RTS, watches for loss of traffic and issues run commands.
  Assumes RXD synchronous to CLOCK, a half-duplex line, and that
  PARAM_DEFAULT is raised together with SYS_RST on first power-up.
*/
module mbs_port
  import mbs_pkg::*;
#(
  parameter int MS_CYCLES = MBS_MS_CYCLES,
  parameter int CLK_HZ    = MBS_CLK_HZ
)(
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        PARAM_DEFAULT,
  input  wire logic        RXD,
  input  wire logic [15:0] OUT_VOLTAGE,
  output logic             TXD,
  output logic             RTS,
  output logic             COMM_FAULT,
  output logic [1:0]       STOP_ACTION,
  output logic             RUN_FWD,
  output logic             RUN_REV
);

  mbs_state_t q;
  mbs_state_t d;
  logic [14:0] bitlen;
  logic        par_on;
  logic [9:0]  rx_sh_n;
  logic [7:0]  rx_byte;
  logic        rx_done;
  logic        rx_err;
  logic [15:0] rx_crc_nx;
  logic [7:0]  tx_byte;
  logic [15:0] tx_crc_nx;
  logic        ms_tick;
  logic        tenth_tick;
  logic [15:0] reg_adr;
  logic [15:0] wr_data;
  logic        hit;
  logic [3:0]  hidx;
  logic        frame_ok;
  logic        is_rd;
  logic        is_wr;
  logic        wr_hit;
  logic [15:0] rd_data;
  logic [6:0]  tw;
  logic        txp;

  // ---------------------------------------------------------------
  // frame check units
  // ---------------------------------------------------------------
  mbs_crc16 u_rx_crc (
    .crc_in  (q.rx_crc),
    .data    (rx_byte),
    .crc_out (rx_crc_nx)
  );

  mbs_crc16 u_tx_crc (
    .crc_in  (q.tx_crc),
    .data    (tx_byte),
    .crc_out (tx_crc_nx)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    bitlen = mbs_bit_cycles(q.act_rate, CLK_HZ);
    par_on = (q.act_par == MBS_PAR_EVEN) || (q.act_par == MBS_PAR_ODD);
    rx_sh_n = {RXD, q.rx_sh[9:1]};
    rx_byte = par_on ? rx_sh_n[7:0] : rx_sh_n[8:1];
    rx_done = 1'b0;
    // parity and stop bit check of the character being completed
    rx_err = !rx_sh_n[9];
    if (q.act_par == MBS_PAR_EVEN && (^rx_sh_n[8:0])) rx_err = 1'b1;
    if (q.act_par == MBS_PAR_ODD && !(^rx_sh_n[8:0])) rx_err = 1'b1;

    // millisecond and tenth-second enables
    ms_tick = (q.ms_cnt == 15'(MS_CYCLES - 1));
    d.ms_cnt = ms_tick ? 15'h0000 : q.ms_cnt + 15'h0001;
    tenth_tick = ms_tick && (q.tenth_cnt == 7'(MBS_LOSS_STEP_MS - 1));
    if (ms_tick) begin
      d.tenth_cnt = tenth_tick ? 7'h00 : q.tenth_cnt + 7'h01;
    end

    // receiver: start detect, bit sampling, gap measure
    if (!q.rx_busy) begin
      if (!RXD) begin
        d.rx_busy = 1'b1;
        d.rx_cnt = bitlen >> 1;
        d.rx_bit = 4'h0;
        if (q.idle_bits >= MBS_GAP_BITS) begin
          d.nbytes = 4'h0;
          d.rx_bad = 1'b0;
          d.rx_crc = MBS_CRC_INIT;
        end
      end else if (q.rx_cnt == 15'h0000) begin
        d.rx_cnt = bitlen - 15'h0001;
        if (q.idle_bits != 6'h3f) d.idle_bits = q.idle_bits + 6'h01;
      end else begin
        d.rx_cnt = q.rx_cnt - 15'h0001;
      end
    end else if (q.rx_cnt != 15'h0000) begin
      d.rx_cnt = q.rx_cnt - 15'h0001;
    end else begin
      d.rx_cnt = bitlen - 15'h0001;
      if (q.rx_bit == 4'h0) begin
        if (RXD) d.rx_busy = 1'b0;
        else d.rx_bit = 4'h1;
      end else begin
        d.rx_sh = rx_sh_n;
        d.rx_bit = q.rx_bit + 4'h1;
        if (q.rx_bit == (par_on ? 4'ha : 4'h9)) begin
          rx_done = 1'b1;
          d.rx_busy = 1'b0;
          d.idle_bits = 6'h00;
        end
      end
    end

    // collect up to eight characters of a frame
    if (rx_done && q.nbytes != 4'h8) begin
      d.rx_buf[q.nbytes[2:0]] = rx_byte;
      d.rx_crc = rx_crc_nx;
      d.nbytes = q.nbytes + 4'h1;
      d.rx_bad = q.rx_bad | rx_err;
    end

    // decode the completed request
    reg_adr = {q.rx_buf[2], q.rx_buf[3]};
    wr_data = {q.rx_buf[4], q.rx_buf[5]};
    hit = 1'b0;
    hidx = 4'h0;
    for (int i = 0; i < MBS_NREG; i++) begin
      if (MBS_REG_OFS[i] == reg_adr) begin
        hit = 1'b1;
        hidx = 4'(i);
      end
    end
    frame_ok = rx_done && q.nbytes == 4'h7 && !q.rx_bad && !rx_err &&
               rx_crc_nx == 16'h0000 && q.st == MBS_ST_IDLE &&
               q.act_addr != 8'h00 &&
               q.rx_buf[0] == q.act_addr;
    is_rd = q.rx_buf[1] == MBS_FN_READ && wr_data == 16'h0001 &&
            (hit || reg_adr == MBS_CMD_REG || reg_adr == MBS_VOLT_REG);
    is_wr = q.rx_buf[1] == MBS_FN_WRITE &&
            (hit || reg_adr == MBS_CMD_REG || reg_adr == MBS_ENTER_REG);
    wr_hit = frame_ok && is_wr;
    if (hit) rd_data = q.shadow[hidx];
    else if (reg_adr == MBS_CMD_REG) rd_data = {14'h0000, q.cmd};
    else if (q.live[MBS_I_VUNIT][0]) rd_data = OUT_VOLTAGE / 16'd10;
    else rd_data = OUT_VOLTAGE;

    // accepted request: apply the write and build the reply
    if (frame_ok && (is_rd || is_wr)) begin
      d.loss_cnt = 7'h00;
      d.fault = 1'b0;
      d.st = MBS_ST_WAIT;
      d.wait_ms = 7'h00;
      d.ms_cnt = 15'h0000;
      if (is_wr) begin
        d.tx_buf = q.rx_buf[5:0];
        d.tx_len = 4'h6;
        if (reg_adr == MBS_CMD_REG) d.cmd = wr_data[1:0];
        if (reg_adr == MBS_ENTER_REG) d.live = q.shadow;
        if (hit) begin
          d.shadow[hidx] = wr_data;
          if (q.live[MBS_I_ENTER][0]) d.live[hidx] = wr_data;
        end
      end else begin
        d.tx_buf = {8'h00, rd_data[7:0], rd_data[15:8], 8'h02,
                    MBS_FN_READ, q.act_addr};
        d.tx_len = 4'h5;
      end
    end

    // loss of traffic detection, clear by an accepted request wins over timeout set
    if (!q.live[MBS_I_LOSS_EN][0]) begin
      d.loss_cnt = 7'h00;
      d.fault = 1'b0;
    end else if (tenth_tick && d.st == MBS_ST_IDLE) begin
      if (q.loss_cnt != 7'h7f) d.loss_cnt = q.loss_cnt + 7'h01;
      if (q.loss_cnt >= q.live[MBS_I_LOSS_T][6:0]) d.fault = 1'b1;
    end

    // turnaround wait, then transmit
    tw = q.live[MBS_I_TXWAIT][6:0];
    if (q.live[MBS_I_TXWAIT] < 16'(MBS_TXWAIT_MIN)) tw = MBS_TXWAIT_MIN;
    if (q.live[MBS_I_TXWAIT] > 16'(MBS_TXWAIT_MAX)) tw = MBS_TXWAIT_MAX;
    if (q.tx_idx < q.tx_len) tx_byte = q.tx_buf[q.tx_idx[2:0]];
    else if (q.tx_idx == q.tx_len) tx_byte = q.tx_crc[7:0];
    else tx_byte = q.tx_crc[15:8];
    txp = 1'b1; // idle level of the parity slot
    case (q.st)
      MBS_ST_IDLE: begin
        d.tx_line = 1'b1;
      end
      MBS_ST_WAIT: begin
        if (ms_tick) d.wait_ms = q.wait_ms + 7'h01;
        if (q.wait_ms >= tw) begin
          d.st = MBS_ST_SEND;
          d.tx_cnt = 15'h0000;
          d.tx_bits = 4'h0;
          d.tx_idx = 4'h0;
          d.tx_crc = MBS_CRC_INIT;
        end
      end
      MBS_ST_SEND: begin
        if (q.tx_cnt != 15'h0000) begin
          d.tx_cnt = q.tx_cnt - 15'h0001;
        end else begin
          d.tx_cnt = bitlen - 15'h0001;
          if (q.tx_bits != 4'h0) begin
            d.tx_line = q.tx_sh[0];
            d.tx_sh = {1'b1, q.tx_sh[9:1]};
            d.tx_bits = q.tx_bits - 4'h1;
          end else if (q.tx_idx < q.tx_len + 4'h2) begin
            txp = 1'b1; // no parity: second stop bit
            if (q.act_par == MBS_PAR_EVEN) txp = ^tx_byte;
            if (q.act_par == MBS_PAR_ODD) txp = ~^tx_byte;
            d.tx_line = 1'b0;
            d.tx_sh = {1'b1, txp, tx_byte};
            d.tx_bits = 4'ha;
            d.tx_idx = q.tx_idx + 4'h1;
            if (q.tx_idx < q.tx_len) d.tx_crc = tx_crc_nx;
          end else begin
            d.st = MBS_ST_IDLE;
            d.tx_line = 1'b1;
          end
        end
      end
      default: begin
        d.st = MBS_ST_IDLE;
      end
    endcase

    // run command decoding and stop action
    if (q.live[MBS_I_RUNM][0]) begin
      d.run_fwd = q.cmd[0] && !q.cmd[1];
      d.run_rev = q.cmd[0] && q.cmd[1];
    end else begin
      d.run_fwd = q.cmd[0] && !q.cmd[1];
      d.run_rev = q.cmd[1] && !q.cmd[0];
    end
    d.stop_act = q.live[MBS_I_STOP][1:0];

    // power-up: settings survive unless PARAM_DEFAULT loads the reset values, serial framing is latched here
    if (SYS_RST) begin
      d = '0;
      d.shadow = PARAM_DEFAULT ? MBS_REG_RST : q.shadow;
      d.live = PARAM_DEFAULT ? MBS_REG_RST : q.live;
      d.act_addr = d.live[MBS_I_ADDR][7:0];
      d.act_rate = d.live[MBS_I_RATE][3:0];
      d.act_par = d.live[MBS_I_PAR][1:0];
      d.rx_crc = MBS_CRC_INIT;
      d.idle_bits = MBS_GAP_BITS;
      d.tx_line = 1'b1;
      d.st = MBS_ST_IDLE;
      d.stop_act = d.live[MBS_I_STOP][1:0];
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    q <= d;
  end

  // pin and status outputs
  assign TXD = q.tx_line;
  assign RTS = (q.st == MBS_ST_SEND) || !q.live[MBS_I_RTS][0];
  assign COMM_FAULT = q.fault;
  assign STOP_ACTION = q.stop_act;
  assign RUN_FWD = q.run_fwd;
  assign RUN_REV = q.run_rev;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  property p_addr_match;
    $rose(q.st == MBS_ST_WAIT) |-> q.rx_buf[0] == q.act_addr;
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("reply to a frame for another station");

  property p_addr_zero;
    q.act_addr == 8'h00 |-> q.st == MBS_ST_IDLE && RTS == !q.live[6][0];
  endproperty
  a_addr_zero: assert property (p_addr_zero)
    else $error("answer given with station address zero");

  property p_latch;
    !$past(SYS_RST) |-> $stable(q.act_addr) && $stable(q.act_rate)
                        && $stable(q.act_par);
  endproperty
  a_latch: assert property (p_latch)
    else $error("framing settings changed without power-up");

  property p_start_bit;
    $rose(q.st == MBS_ST_SEND) |=> !TXD;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("no start bit after entering send");

  property p_stop_act;
    ##1 $changed(q.live[3][1:0]) |=> STOP_ACTION == $past(q.live[3][1:0]);
  endproperty
  a_stop_act: assert property (p_stop_act)
    else $error("stop action does not follow its setting");

  property p_fault_off;
    !q.live[4][0] |=> !COMM_FAULT;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("fault with loss detection disabled");

  property p_wait_min;
    $rose(q.st == MBS_ST_SEND) |-> $past(q.wait_ms) >= MBS_TXWAIT_MIN;
  endproperty
  a_wait_min: assert property (p_wait_min)
    else $error("reply started before the turnaround wait");

  property p_rts;
    q.live[6][0] |-> RTS == (q.st == MBS_ST_SEND);
  endproperty
  a_rts: assert property (p_rts)
    else $error("RTS asserted outside sending");

  property p_enter;
    wr_hit && reg_adr != MBS_ENTER_REG && !q.live[9][0] |=> $stable(q.live);
  endproperty
  a_enter: assert property (p_enter)
    else $error("write applied without enter command");

  property p_run;
    !(RUN_FWD && RUN_REV);
  endproperty
  a_run: assert property (p_run)
    else $error("forward and reverse run together");

  property p_tx_idle;
    q.st != MBS_ST_SEND |-> TXD;
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("line driven low outside a reply");

  c_reply: cover property ($rose(q.st == MBS_ST_SEND));
  c_fault: cover property ($rose(COMM_FAULT));
  c_enter: cover property (wr_hit && reg_adr == MBS_ENTER_REG);

endmodule

// ==== dv/mbs_master.sv ====
/*
  Serial master model for the port: sends request frames and collects
  replies. Assumes the bench sets bit_cyc and calls one task at a time.
*/
module mbs_master (
  input  wire logic clk,
  input  wire logic txd_in,
  input  wire logic rts_in,
  output logic      rxd_out
);
  timeunit 1ns;
  timeprecision 1ns;

  int         bit_cyc = 2083;  // clocks per bit
  int         cyc     = 0;
  int         stop_at;         // cycle of last request stop bit
  int         first_start;     // cycle of first reply start bit
  int         wait_max = 0;    // longest reply turnaround, clocks
  logic       rts_pre;
  logic       rts_on;
  logic [7:0] rx_q [$];

  // cycle count and idle line level
  always @(posedge clk) cyc <= cyc + 1;
  initial rxd_out = 1'b1;

  // start, 8 data lsb first, one stop, no parity
  task automatic put_char(input logic [7:0] b);
    logic [9:0] s;
    s = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (i == 9) stop_at = cyc;
      rxd_out = s[i];
      repeat (bit_cyc) @(negedge clk);
    end
  endtask

  // request after a silent gap, check word low byte first
  task automatic send(input logic [7:0] a, f, input logic [15:0] r, d);
    logic [7:0]  q [$];
    logic [15:0] c;
    q = '{a, f, r[15:8], r[7:0], d[15:8], d[7:0]};
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    repeat (36 * bit_cyc) @(negedge clk);
    foreach (q[i]) put_char(q[i]);
  endtask

  // collect n reply characters; ok drops if the line stays idle
  task automatic recv(input int n, output bit ok);
    int         t;
    logic [7:0] b;
    rx_q = {};
    ok   = 1'b1;
    for (int k = 0; k < n && ok; k++) begin
      t = 0;
      while (txd_in !== 1'b0 && t < 40 * bit_cyc + wait_max) begin
        if (k == 0 && t == 0) rts_pre = rts_in;
        @(negedge clk);
        t++;
      end
      ok = (txd_in === 1'b0);
      if (k == 0) first_start = cyc;
      if (k == 0) rts_on = rts_in;
      repeat (bit_cyc / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(negedge clk);
        b[i] = txd_in;
      end
      repeat (bit_cyc) @(negedge clk);
      rx_q.push_back(b);
    end
  endtask
endmodule

// ==== dv/tb_top.sv ====
/*
  Bench of the serial slave port: moves the link to the top rate, reads
  a table of registers, then checks wait time, RTS, run bits, voltage
  units, loss fault and address latching. Assumes mbs_master as master.
*/
module tb_top
  import mbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int MS  = 10;       // clocks per ms, shortened
  localparam int CLK = 600_000;  // nominal clock rate, shortens bit times

  typedef struct {
    logic [7:0]  a;
    logic [15:0] r;
    logic [15:0] n;
    bit          rep;
    logic [15:0] v;
  } mbs_row_t;

  logic        clock         = 1'b0;
  logic        sys_rst       = 1'b1;
  logic        param_default = 1'b1;
  logic [15:0] out_voltage   = 16'h0e6b;
  logic        rxd;
  logic        txd;
  logic        rts;
  logic        comm_fault;
  logic [1:0]  stop_action;
  logic        run_fwd;
  logic        run_rev;
  int          err_count     = 0;
  int          n_tests       = 0;

  // register reads: address, register, count, answered, value
  mbs_row_t rows [13] = '{
    '{8'h1f, 16'h0425, 16'h0001, 1'b1, 16'h001f},
    '{8'h1f, 16'h0426, 16'h0001, 1'b1, 16'h0008},
    '{8'h1f, 16'h0427, 16'h0001, 1'b1, 16'h0000},
    '{8'h1f, 16'h0428, 16'h0001, 1'b1, 16'h0003},
    '{8'h1f, 16'h0429, 16'h0001, 1'b1, 16'h0000},
    '{8'h1f, 16'h042a, 16'h0001, 1'b1, 16'h0005},
    '{8'h1f, 16'h042b, 16'h0001, 1'b1, 16'h0001},
    '{8'h1f, 16'h0435, 16'h0001, 1'b1, 16'h0014},
    '{8'h1f, 16'h043c, 16'h0001, 1'b1, 16'h0000},
    '{8'h1f, 16'h0025, 16'h0001, 1'b1, 16'h0e6b},
    '{8'h05, 16'h0425, 16'h0001, 1'b0, 16'h0000},
    '{8'h1f, 16'h0500, 16'h0001, 1'b0, 16'h0000},
    '{8'h1f, 16'h0425, 16'h0002, 1'b0, 16'h0000}
  };

  // ------------------------------------------------------------
  // design and master
  // ------------------------------------------------------------
  always #25 clock = ~clock;

  mbs_port #(
    .MS_CYCLES (MS),
    .CLK_HZ    (CLK)
  ) mbs_port_inst (
    .CLOCK         (clock),
    .SYS_RST       (sys_rst),
    .PARAM_DEFAULT (param_default),
    .RXD           (rxd),
    .OUT_VOLTAGE   (out_voltage),
    .TXD           (txd),
    .RTS           (rts),
    .COMM_FAULT    (comm_fault),
    .STOP_ACTION   (stop_action),
    .RUN_FWD       (run_fwd),
    .RUN_REV       (run_rev)
  );

  mbs_master mbs_master_inst (
    .clk     (clock),
    .txd_in  (txd),
    .rts_in  (rts),
    .rxd_out (rxd)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic do_reset(input logic dflt);
    @(negedge clock);
    param_default = dflt;
    sys_rst       = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst       = 1'b0;
    param_default = 1'b0;
  endtask

  // one request and its reply, data word compared
  task automatic ask(input logic [7:0] a, f, input logic [15:0] r, d,
                     input bit rep, input logic [15:0] v);
    bit ok;
    int i;
    i = (f == 8'h03) ? 3 : 4;
    mbs_master_inst.send(a, f, r, d);
    mbs_master_inst.recv(i + 4, ok);
    chk(16'(ok), 16'(rep));
    if (rep && !ok) end_of_test();
    if (ok) chk({mbs_master_inst.rx_q[i], mbs_master_inst.rx_q[i + 1]}, v);
  endtask

  task automatic wr(input logic [15:0] r, d);
    ask(8'h1f, 8'h06, r, d, 1'b1, d);
  endtask

  task automatic ent();
    wr(16'h0900, 16'h0000);
  endtask

  task automatic run(input logic [15:0] d, e);
    wr(16'h0001, d);
    chk({14'h0, run_fwd, run_rev}, e);
  endtask

  // reply start measured from the last request stop bit
  task automatic tim(input int tw);
    int d;
    d = mbs_master_inst.first_start - mbs_master_inst.stop_at
        - mbs_master_inst.bit_cyc / 2 - tw * MS;
    chk(16'(d >= -2 && d <= 8), 16'h0001);
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    mbs_master_inst.bit_cyc  = (CLK + MBS_BAUD[3] / 2) / MBS_BAUD[3];
    mbs_master_inst.wait_max = 70 * MS;
    do_reset(1'b1);
    chk({9'h0, txd, rts, comm_fault, run_fwd, run_rev, stop_action}, 16'h43);
    mbs_master_inst.send(8'h1f, 8'h06, 16'h0426, 16'h0008);
    do_reset(1'b0);
    mbs_master_inst.send(8'h1f, 8'h06, 16'h0900, 16'h0000);
    do_reset(1'b0);
    mbs_master_inst.bit_cyc = (CLK + MBS_BAUD[8] / 2) / MBS_BAUD[8];
    foreach (rows[i]) begin
      ask(rows[i].a, 8'h03, rows[i].r, rows[i].n, rows[i].rep, rows[i].v);
    end
    wr(16'h042a, 16'h0041);
    tim(5);
    chk({14'h0, mbs_master_inst.rts_pre, mbs_master_inst.rts_on}, 16'h1);
    ent();
    ask(8'h1f, 8'h03, 16'h042a, 16'h0001, 1'b1, 16'h0041);
    tim(65);
    wr(16'h042b, 16'h0000);
    ent();
    chk(16'(rts), 16'h0001);
    run(16'h0001, 16'h0002);
    run(16'h0003, 16'h0000);
    run(16'h0002, 16'h0001);
    wr(16'h043d, 16'h0001);
    ent();
    run(16'h0003, 16'h0001);
    run(16'h0001, 16'h0002);
    wr(16'h0436, 16'h0001);
    ent();
    ask(8'h1f, 8'h03, 16'h0025, 16'h0001, 1'b1, 16'h0171);
    wr(16'h0435, 16'h0001);
    wr(16'h0428, 16'h0001);
    wr(16'h0429, 16'h0001);
    ent();
    for (int i = 0; i < 600 * MS && comm_fault !== 1'b1; i++) begin
      @(negedge clock);
    end
    chk(16'(comm_fault), 16'h0001);
    if (comm_fault !== 1'b1) end_of_test();
    chk(16'(stop_action), 16'h0001);
    ask(8'h1f, 8'h03, 16'h0429, 16'h0001, 1'b1, 16'h0001);
    chk(16'(comm_fault), 16'h0000);
    wr(16'h0429, 16'h0000);
    ent();
    repeat (1000 * MS) @(negedge clock);
    chk(16'(comm_fault), 16'h0000);
    wr(16'h0425, 16'h0000);
    ent();
    ask(8'h1f, 8'h03, 16'h0425, 16'h0001, 1'b1, 16'h0000);
    do_reset(1'b0);
    ask(8'h00, 8'h03, 16'h0425, 16'h0001, 1'b0, 16'h0000);
    ask(8'h1f, 8'h03, 16'h0425, 16'h0001, 1'b0, 16'h0000);
    end_of_test();
  end

  // hang guard
  initial begin
    repeat (120_000) @(posedge clock);
    err_count++;
    end_of_test();
  end
endmodule
